// *** hw/lscr_pkg.sv ***
// constants and field layout of the indicator and strap register bank
// Overview of operation
// - four-bit source select at bits 7-4, reset 0x1; code 0xF reserved.
// - codes 0-4 select link-good, any activity, tx, rx, collision.
// - codes 5, 6, 7 select 100 Mb/s, 10 Mb/s, full duplex.
// - code 8 is link on with activity blink; code 9 stretched activity.
// - code A is link at 100 full duplex; code B is low-power idle.
// - code C lights on a transmit or receive MAC-side error.
// - code D lights on link loss until basic status 0x0001 is read.
// - code E latches on test pattern error until its counter clears.
// - strapped address bits 1 and 0 read at bits 13 and 12.
// - strapped crossover mode at bit 8, reset 1, 1 means automatic.
// - strapped RMII role at bit 3, 0 master 25MHz, 1 slave 50MHz.
// - strapped auto-negotiation enable at bit 0, reset 1.
// - strapped link indicator polarity at second strap bit 7, reset 1.
// - polarity bits 6 (second, reset 1) and 2 (first, strap loaded).
// - drive-enable bits 4 and 0 force software level when set.
package lscr_pkg;

   localparam int AW = 16;
   localparam int DW = 16;

   localparam logic [15:0] ADDR_BASIC_STATUS = 16'h0001;
   localparam logic [15:0] ADDR_SRC_CFG      = 16'h0460;
   localparam logic [15:0] ADDR_IO_CTRL      = 16'h0461;
   localparam logic [15:0] ADDR_STRAP_FIRST  = 16'h0467;
   localparam logic [15:0] ADDR_STRAP_SECOND = 16'h0468;
   localparam logic [15:0] ADDR_DRIVE_POL    = 16'h0469;

   localparam logic [15:0] RST_SRC_CFG       = 16'h0010;
   localparam logic [15:0] RST_STRAP_FIRST   = 16'h0101;
   localparam logic [15:0] RST_STRAP_SECOND  = 16'h0080;
   localparam logic [15:0] RST_DRIVE_POL     = 16'h0040;

   localparam int SRC_LSB = 4;
   localparam int SRC_MSB = 7;

   localparam int SF_ADDR1    = 13;
   localparam int SF_ADDR0    = 12;
   localparam int SF_CROSS    = 8;
   localparam int SF_RMII     = 3;
   localparam int SF_AUTONEG  = 0;
   localparam int SS_VALIDSEL = 11;
   localparam int SS_LINKPOL  = 7;

   localparam int DP_POL2 = 6;
   localparam int DP_VAL2 = 5;
   localparam int DP_EN2  = 4;
   localparam int DP_POL1 = 2;
   localparam int DP_VAL1 = 1;
   localparam int DP_EN1  = 0;

   localparam logic [3:0] SRC_LINK      = 4'h0;
   localparam logic [3:0] SRC_ACT       = 4'h1;
   localparam logic [3:0] SRC_TX_ACT    = 4'h2;
   localparam logic [3:0] SRC_RX_ACT    = 4'h3;
   localparam logic [3:0] SRC_COLL      = 4'h4;
   localparam logic [3:0] SRC_SPD100    = 4'h5;
   localparam logic [3:0] SRC_SPD10     = 4'h6;
   localparam logic [3:0] SRC_FDX       = 4'h7;
   localparam logic [3:0] SRC_LINK_BLNK = 4'h8;
   localparam logic [3:0] SRC_STRETCH   = 4'h9;
   localparam logic [3:0] SRC_LINK100FD = 4'hA;
   localparam logic [3:0] SRC_LPI       = 4'hB;
   localparam logic [3:0] SRC_MII_ERR   = 4'hC;
   localparam logic [3:0] SRC_LINK_LOST = 4'hD;
   localparam logic [3:0] SRC_PATT_ERR  = 4'hE;
   localparam logic [3:0] SRC_RSVD      = 4'hF;

   localparam int CLK_NS  = 40;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] STRETCH_TICKS = 6'h32;
   localparam logic [5:0] BLINK_TICKS   = 6'h32;
   localparam logic [1:0] STRAP_SETTLE  = 2'h2;
   localparam int STRAP_W = 7;

endpackage

// *** hw/lscr_sync.sv ***
// two-flop synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none
module lscr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);

   logic [W-1:0] meta;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               meta[g] <= 1'b0;
               q_o[g]  <= 1'b0;
            end else begin
               meta[g] <= d_i[g];
               q_o[g]  <= meta[g];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// *** hw/lscr_regs.sv ***
// indicator source, strap observation and indicator drive register bank
`timescale 1ns/1ps
`default_nettype none
module lscr_regs #(
   parameter int TICK_CYCLES = lscr_pkg::TICK_CYC
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   input  wire logic [15:0] ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output var  logic [15:0] RDATA_O,
   input  wire logic        LINK_GOOD_I,
   input  wire logic        TX_ACT_I,
   input  wire logic        RX_ACT_I,
   input  wire logic        COLLISION_I,
   input  wire logic        SPEED_100_I,
   input  wire logic        SPEED_10_I,
   input  wire logic        FULL_DUPLEX_I,
   input  wire logic        LPI_I,
   input  wire logic        MII_TX_ERR_I,
   input  wire logic        MII_RX_ERR_I,
   input  wire logic        PATTERN_ERR_I,
   input  wire logic        PATTERN_CNT_CLR_I,
   input  wire logic        STRAP_ADDR_BIT1_I,
   input  wire logic        STRAP_ADDR_BIT0_I,
   input  wire logic        STRAP_AUTO_CROSSOVER_I,
   input  wire logic        STRAP_RMII_SLAVE_I,
   input  wire logic        STRAP_AUTONEG_I,
   input  wire logic        STRAP_LINK_INDICATOR_POL_I,
   input  wire logic        STRAP_VALID_SIGNAL_CHOICE_I,
   output var  logic        IND1_O,
   output var  logic        IND2_O
);

   // software visible state
   logic [3:0]  src_sel;
   logic        pol2;
   logic        val2;
   logic        en2;
   logic        pol1;
   logic        val1;
   logic        en1;

   // latched strap values
   logic        strap_addr_bit1;
   logic        strap_addr_bit0;
   logic        strap_auto_crossover;
   logic        strap_rmii_slave;
   logic        strap_autoneg;
   logic        strap_link_indicator_pol;
   logic        strap_valid_signal_choice;
   logic [1:0]  strap_wait;
   logic        strap_done;
   logic        strap_take;
   logic [lscr_pkg::STRAP_W-1:0] strap_raw;
   logic [lscr_pkg::STRAP_W-1:0] strap_sync;

   // time base and event state
   logic [23:0] tick_cnt;
   logic        tick;
   logic [5:0]  stretch_cnt;
   logic        act_stretch;
   logic [5:0]  blink_cnt;
   logic        blink_phase;
   logic        link_prev;
   logic        link_lost;
   logic        patt_err_hold;

   // decode
   logic        wr_src;
   logic        wr_drv;
   logic        rd_status;
   logic [15:0] next_rdata;
   logic        raw1;
   logic        lvl1;
   logic        lvl2;
   logic        next_ind1;
   logic        next_ind2;

   assign wr_src    = WR_I && (ADDR_I == lscr_pkg::ADDR_SRC_CFG);
   assign wr_drv    = WR_I && (ADDR_I == lscr_pkg::ADDR_DRIVE_POL);
   // basic status lives elsewhere; this bank only watches the read
   assign rd_status = RD_I && (ADDR_I == lscr_pkg::ADDR_BASIC_STATUS);

   // strap pins come from the board, so they are synchronised first
   assign strap_raw = {STRAP_VALID_SIGNAL_CHOICE_I,
                       STRAP_LINK_INDICATOR_POL_I,
                       STRAP_AUTONEG_I,
                       STRAP_RMII_SLAVE_I,
                       STRAP_AUTO_CROSSOVER_I,
                       STRAP_ADDR_BIT0_I,
                       STRAP_ADDR_BIT1_I};

   lscr_sync #(
      .W (lscr_pkg::STRAP_W)
   ) u_strap_sync (
      .clk_i    (CLK_SYS_I),
      .resetn_i (RESETN_I),
      .d_i      (strap_raw),
      .q_o      (strap_sync)
   );

   // wait for the synchroniser to fill before sampling the straps once
   assign strap_take = !strap_done && (strap_wait == lscr_pkg::STRAP_SETTLE);

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         strap_wait <= 2'h0;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         if (strap_take) begin
            strap_done <= 1'b1;
         end else begin
            strap_wait <= strap_wait + 2'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         strap_addr_bit1           <= lscr_pkg::RST_STRAP_FIRST[lscr_pkg::SF_ADDR1];
         strap_addr_bit0           <= lscr_pkg::RST_STRAP_FIRST[lscr_pkg::SF_ADDR0];
         strap_auto_crossover      <= lscr_pkg::RST_STRAP_FIRST[lscr_pkg::SF_CROSS];
         strap_rmii_slave          <= lscr_pkg::RST_STRAP_FIRST[lscr_pkg::SF_RMII];
         strap_autoneg             <= lscr_pkg::RST_STRAP_FIRST[lscr_pkg::SF_AUTONEG];
         strap_link_indicator_pol  <= lscr_pkg::RST_STRAP_SECOND[lscr_pkg::SS_LINKPOL];
         strap_valid_signal_choice <= lscr_pkg::RST_STRAP_SECOND[lscr_pkg::SS_VALIDSEL];
      end else if (strap_take) begin
         strap_addr_bit1           <= strap_sync[0];
         strap_addr_bit0           <= strap_sync[1];
         strap_auto_crossover      <= strap_sync[2];
         strap_rmii_slave          <= strap_sync[3];
         strap_autoneg             <= strap_sync[4];
         strap_link_indicator_pol  <= strap_sync[5];
         strap_valid_signal_choice <= strap_sync[6];
      end
   end

   // source select register
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         src_sel <= lscr_pkg::RST_SRC_CFG[lscr_pkg::SRC_MSB:lscr_pkg::SRC_LSB];
      end else if (wr_src) begin
         // other bits of the word are dropped
         src_sel <= WDATA_I[lscr_pkg::SRC_MSB:lscr_pkg::SRC_LSB];
      end
   end

   // drive and polarity register; a software write beats the strap load
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         pol2 <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_POL2];
         val2 <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_VAL2];
         en2  <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_EN2];
         pol1 <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_POL1];
         val1 <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_VAL1];
         en1  <= lscr_pkg::RST_DRIVE_POL[lscr_pkg::DP_EN1];
      end else if (wr_drv) begin
         pol2 <= WDATA_I[lscr_pkg::DP_POL2];
         val2 <= WDATA_I[lscr_pkg::DP_VAL2];
         en2  <= WDATA_I[lscr_pkg::DP_EN2];
         pol1 <= WDATA_I[lscr_pkg::DP_POL1];
         val1 <= WDATA_I[lscr_pkg::DP_VAL1];
         en1  <= WDATA_I[lscr_pkg::DP_EN1];
      end else if (strap_take) begin
         pol1 <= strap_sync[5];
      end
   end

   // millisecond time base for stretch and blink
   assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         tick_cnt <= 24'h00_0000;
      end else if (tick) begin
         tick_cnt <= 24'h00_0000;
      end else begin
         tick_cnt <= tick_cnt + 24'h00_0001;
      end
   end

   // activity stretch, retriggered by every activity cycle
   assign act_stretch = (stretch_cnt != 6'h00);

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         stretch_cnt <= 6'h00;
      end else if (TX_ACT_I || RX_ACT_I) begin
         stretch_cnt <= lscr_pkg::STRETCH_TICKS;
      end else if (tick && act_stretch) begin
         stretch_cnt <= stretch_cnt - 6'h01;
      end
   end

   // free running blink phase; cheaper than restarting it per burst
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         blink_cnt   <= 6'h00;
         blink_phase <= 1'b0;
      end else if (tick) begin
         if (blink_cnt == lscr_pkg::BLINK_TICKS - 6'h01) begin
            blink_cnt   <= 6'h00;
            blink_phase <= !blink_phase;
         end else begin
            blink_cnt <= blink_cnt + 6'h01;
         end
      end
   end

   // link lost latch; a new loss in the clearing cycle wins
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         link_prev <= 1'b0;
         link_lost <= 1'b0;
      end else begin
         link_prev <= LINK_GOOD_I;
         if (link_prev && !LINK_GOOD_I) begin
            link_lost <= 1'b1;
         end else if (rd_status) begin
            link_lost <= 1'b0;
         end
      end
   end

   // test pattern error latch; an error in the clearing cycle wins
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         patt_err_hold <= 1'b0;
      end else if (PATTERN_ERR_I) begin
         patt_err_hold <= 1'b1;
      end else if (PATTERN_CNT_CLR_I) begin
         patt_err_hold <= 1'b0;
      end
   end

   // event source for the first indicator
   always_comb begin
      unique case (src_sel)
         lscr_pkg::SRC_LINK:      raw1 = LINK_GOOD_I;
         lscr_pkg::SRC_ACT:       raw1 = TX_ACT_I || RX_ACT_I;
         lscr_pkg::SRC_TX_ACT:    raw1 = TX_ACT_I;
         lscr_pkg::SRC_RX_ACT:    raw1 = RX_ACT_I;
         lscr_pkg::SRC_COLL:      raw1 = COLLISION_I;
         lscr_pkg::SRC_SPD100:    raw1 = SPEED_100_I;
         lscr_pkg::SRC_SPD10:     raw1 = SPEED_10_I;
         lscr_pkg::SRC_FDX:       raw1 = FULL_DUPLEX_I;
         lscr_pkg::SRC_LINK_BLNK: raw1 = LINK_GOOD_I &&
                                         !(act_stretch && blink_phase);
         lscr_pkg::SRC_STRETCH:   raw1 = act_stretch;
         lscr_pkg::SRC_LINK100FD: raw1 = LINK_GOOD_I && SPEED_100_I &&
                                         FULL_DUPLEX_I;
         lscr_pkg::SRC_LPI:       raw1 = LPI_I;
         lscr_pkg::SRC_MII_ERR:   raw1 = MII_TX_ERR_I || MII_RX_ERR_I;
         lscr_pkg::SRC_LINK_LOST: raw1 = link_lost;
         lscr_pkg::SRC_PATT_ERR:  raw1 = patt_err_hold;
         lscr_pkg::SRC_RSVD:      raw1 = 1'b0;
      endcase
   end

   // override then polarity; second indicator normally shows link
   assign lvl1      = en1 ? val1 : raw1;
   assign lvl2      = en2 ? val2 : LINK_GOOD_I;
   assign next_ind1 = pol1 ? lvl1 : !lvl1;
   assign next_ind2 = pol2 ? lvl2 : !lvl2;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         IND1_O <= 1'b1;
         IND2_O <= 1'b0;
      end else begin
         IND1_O <= next_ind1;
         IND2_O <= next_ind2;
      end
   end

   // read mux; unlisted bits and addresses return zero
   always_comb begin
      next_rdata = 16'h0000;
      unique case (ADDR_I)
         lscr_pkg::ADDR_SRC_CFG: begin
            next_rdata[lscr_pkg::SRC_MSB:lscr_pkg::SRC_LSB] = src_sel;
         end
         lscr_pkg::ADDR_IO_CTRL: begin
            next_rdata = 16'h0000;
         end
         lscr_pkg::ADDR_STRAP_FIRST: begin
            next_rdata[lscr_pkg::SF_ADDR1]   = strap_addr_bit1;
            next_rdata[lscr_pkg::SF_ADDR0]   = strap_addr_bit0;
            next_rdata[lscr_pkg::SF_CROSS]   = strap_auto_crossover;
            next_rdata[lscr_pkg::SF_RMII]    = strap_rmii_slave;
            next_rdata[lscr_pkg::SF_AUTONEG] = strap_autoneg;
         end
         lscr_pkg::ADDR_STRAP_SECOND: begin
            next_rdata[lscr_pkg::SS_VALIDSEL] = strap_valid_signal_choice;
            next_rdata[lscr_pkg::SS_LINKPOL]  = strap_link_indicator_pol;
         end
         lscr_pkg::ADDR_DRIVE_POL: begin
            next_rdata[lscr_pkg::DP_POL2] = pol2;
            next_rdata[lscr_pkg::DP_VAL2] = val2;
            next_rdata[lscr_pkg::DP_EN2]  = en2;
            next_rdata[lscr_pkg::DP_POL1] = pol1;
            next_rdata[lscr_pkg::DP_VAL1] = val1;
            next_rdata[lscr_pkg::DP_EN1]  = en1;
         end
         default: begin
            next_rdata = 16'h0000;
         end
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         RDATA_O <= 16'h0000;
      end else if (RD_I) begin
         RDATA_O <= next_rdata;
      end else begin
         RDATA_O <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// *** verification/lscr_board.sv ***
// board strap resistors feeding the strap pins of the register bank
`timescale 1ns/1ps
`default_nettype none
module lscr_board (
   input  wire logic [6:0] pick_i,
   output var  logic [6:0] strap_o
);
   // resistors are static: the level never moves after power up
   always_comb strap_o = pick_i;
endmodule
`default_nettype wire

// *** verification/lscr_regs_properties.sv ***
// concurrent checks on the indicator and strap register bank ports
`timescale 1ns/1ps
`default_nettype none
module lscr_regs_chk #(
   parameter int TICK_CYCLES = 4
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   input  wire logic [15:0] ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   input  wire logic [15:0] RDATA_O,
   input  wire logic        LINK_GOOD_I,
   input  wire logic        PATTERN_ERR_I,
   input  wire logic        IND1_O,
   input  wire logic        IND2_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   logic [15:0] src_q;
   logic [15:0] drv_q;
   logic        mapped;
   logic        norm1;
   // shadow copies only, strap load of pol1 is not tracked
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         src_q <= 16'h0010;
         drv_q <= 16'h0040;
      end else if (WR_I && ADDR_I == 16'h0460) begin
         src_q <= WDATA_I;
      end else if (WR_I && ADDR_I == 16'h0469) begin
         drv_q <= WDATA_I;
      end
   end
   assign mapped = ADDR_I == 16'h0460 || ADDR_I == 16'h0467 ||
                   ADDR_I == 16'h0468 || ADDR_I == 16'h0469;
   assign norm1 = drv_q[2] && !drv_q[0];
   a_idle_rdata_zero: assert property (
      !RD_I |=> RDATA_O == 16'h0000)
      else $error("read data not zero outside read");
   a_unmapped_zero: assert property (
      RD_I && !mapped |=> RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   a_src_rsvd_zero: assert property (
      RD_I && ADDR_I == 16'h0460 |=> (RDATA_O & 16'hFF0F) == 16'h0000)
      else $error("source register reserved bits set");
   a_strap1_rsvd: assert property (
      RD_I && ADDR_I == 16'h0467 |=> (RDATA_O & 16'hCEF6) == 16'h0000)
      else $error("first strap reserved bits set");
   a_strap2_rsvd: assert property (
      RD_I && ADDR_I == 16'h0468 |=> (RDATA_O & 16'hF77F) == 16'h0000)
      else $error("second strap reserved bits set");
   a_drive_rsvd: assert property (
      RD_I && ADDR_I == 16'h0469 |=> (RDATA_O & 16'hFF88) == 16'h0000)
      else $error("drive register reserved bits set");
   a_src_readback: assert property (
      WR_I && ADDR_I == 16'h0460 ##1 RD_I && ADDR_I == 16'h0460
      |=> RDATA_O == (src_q & 16'h00F0))
      else $error("source select readback wrong");
   a_force_ind1: assert property (
      drv_q[0] && $stable(drv_q) |-> IND1_O == !(drv_q[1] ^ drv_q[2]))
      else $error("first indicator forced level wrong");
   a_force_ind2: assert property (
      drv_q[4] && $stable(drv_q) |-> IND2_O == !(drv_q[5] ^ drv_q[6]))
      else $error("second indicator forced level wrong");
   a_lost_lights: assert property (
      src_q[7:4] == 4'hD && norm1 && $fell(LINK_GOOD_I)
      |-> ##[1:3] IND1_O)
      else $error("link loss did not light indicator");
   a_pattern_lights: assert property (
      src_q[7:4] == 4'hE && norm1 && $rose(PATTERN_ERR_I)
      |-> ##[1:3] IND1_O)
      else $error("pattern error did not light indicator");
   c_strap_read: cover property (RD_I && ADDR_I == 16'h0467);
   c_forced: cover property (drv_q[0] && drv_q[4] && IND1_O);
   c_lost_lit: cover property (src_q[7:4] == 4'hD && IND1_O);
endmodule
bind lscr_regs lscr_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .LINK_GOOD_I(LINK_GOOD_I), .PATTERN_ERR_I(PATTERN_ERR_I),
   .IND1_O(IND1_O), .IND2_O(IND2_O));
`default_nettype wire

// *** verification/test_led_and_strap_config_regs.sv ***
// self-checking bench for the indicator and strap register bank
`timescale 1ns/1ps
`default_nettype none
module test_led_and_strap_config_regs;
   localparam int TICK = 4;
   localparam int QUIET = 50 * TICK + 60;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        look = 1'b0;
   logic        rd_seen = 1'b0;
   logic        dark_win = 1'b0;
   logic        dark_chk = 1'b0;
   logic        dark = 1'b0;
   logic [15:0] rdata;
   logic [11:0] st = 12'h000;
   logic [6:0]  pick = 7'h00;
   logic [6:0]  strap;
   logic        ind1;
   logic        ind2;
   logic [15:0] rd_q[$];
   logic [1:0]  ind_q[$];
   logic [3:0]  codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF};
   int          err_total = 0;
   int          n_tests = 0;
   int          cyc = 0;

   lscr_board u_board (.pick_i(pick), .strap_o(strap));
   lscr_regs #(.TICK_CYCLES(TICK)) dut (
      .CLK_SYS_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK_GOOD_I(st[0]),
      .TX_ACT_I(st[1]), .RX_ACT_I(st[2]), .COLLISION_I(st[3]),
      .SPEED_100_I(st[4]), .SPEED_10_I(st[5]), .FULL_DUPLEX_I(st[6]),
      .LPI_I(st[7]), .MII_TX_ERR_I(st[8]), .MII_RX_ERR_I(st[9]),
      .PATTERN_ERR_I(st[10]), .PATTERN_CNT_CLR_I(st[11]),
      .STRAP_ADDR_BIT1_I(strap[6]), .STRAP_ADDR_BIT0_I(strap[5]),
      .STRAP_AUTO_CROSSOVER_I(strap[4]), .STRAP_RMII_SLAVE_I(strap[3]),
      .STRAP_AUTONEG_I(strap[2]), .STRAP_LINK_INDICATOR_POL_I(strap[1]),
      .STRAP_VALID_SIGNAL_CHOICE_I(strap[0]), .IND1_O(ind1), .IND2_O(ind2));

   always #20 clk = ~clk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr16(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= d;
   endtask

   task automatic rd16(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      rd_q.push_back(e);
   endtask

   task automatic idle(input int n);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   // three edges: input sampled, latch set, pin registered
   task automatic look_for(input logic [1:0] e);
      idle(3);
      ind_q.push_back(e);
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
   endtask

   function automatic logic ev(input logic [3:0] c, input logic [11:0] s);
      case (c)
         4'h0: ev = s[0];
         4'h1: ev = s[1] | s[2];
         4'h2: ev = s[1];
         4'h3: ev = s[2];
         4'h4: ev = s[3];
         4'h5: ev = s[4];
         4'h6: ev = s[5];
         4'h7: ev = s[6];
         4'hA: ev = s[0] & s[4] & s[6];
         4'hB: ev = s[7];
         4'hC: ev = s[8] | s[9];
         default: ev = 1'b0;
      endcase
   endfunction

   always @(posedge clk) begin
      if (rd_seen) begin
         check(rdata, rd_q.pop_front());
      end
      if (look) begin
         check(16'({ind2, ind1}), 16'(ind_q.pop_front()));
      end
      // blink phase is free running, so only its presence is checked
      if (dark_win && !ind1) begin
         dark <= 1'b1;
      end
      if (dark_chk) begin
         check({15'h0000, dark}, 16'h0001);
      end
      rd_seen <= rd;
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      logic [3:0]  c;
      logic [1:0]  p;
      logic [11:0] s;
      logic [15:0] r;
      logic [2:0]  k;
      logic [15:0] sor1;
      void'($urandom(44840));
      pick = 7'($urandom);
      sor1 = {2'h0, pick[6], pick[5], 3'h0, pick[4], 4'h0,
              pick[3], 2'h0, pick[2]};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      idle(6);
      look_for({1'b0, !pick[1]});
      rd16(16'h0460, 16'h0010);
      rd16(16'h0467, sor1);
      rd16(16'h0468, {4'h0, pick[0], 3'h0, pick[1], 7'h0});
      rd16(16'h0469, 16'h0040 | {13'h0000, pick[1], 2'h0});
      wr16(16'h0467, 16'hFFFF);
      rd16(16'h0467, sor1);
      wr16(16'h0461, 16'hFFFF);
      rd16(16'h0461, 16'h0000);
      rd16(16'h0001, 16'h0000);
      rd16(16'h0470, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         r = 16'($urandom);
         wr16(16'h0460, r);
         rd16(16'h0460, r & 16'h00F0);
         wr16(16'h0469, r);
         rd16(16'h0469, r & 16'h0077);
      end
      for (int i = 0; i < 36; i++) begin
         c = codes[i % 12];
         p = 2'($urandom);
         s = 12'($urandom) & 12'h3FF;
         wr16(16'h0469, {9'h0, p[1], 3'h0, p[0], 2'h0});
         wr16(16'h0460, {8'h0, c, 4'h0});
         rd16(16'h0460, {8'h0, c, 4'h0});
         idle(0);
         st <= s;
         look_for({!(p[1] ^ s[0]),
                   !(p[0] ^ ev(c, s))});
      end
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         wr16(16'h0469, {9'h0, k[2], k[1], 1'b1, 1'b0, k[1], k[0], 1'b1});
         idle(0);
         st <= 12'($urandom) & 12'h3FF;
         look_for({!(k[1] ^ k[2]), !(k[0] ^ k[1])});
      end
      wr16(16'h0469, 16'h0044);
      wr16(16'h0460, 16'h0090);
      idle(0);
      st <= 12'h001;
      idle(QUIET);
      look_for(2'b10);
      st <= 12'h005;
      @(posedge clk);
      st <= 12'h001;
      look_for(2'b11);
      idle(QUIET);
      look_for(2'b10);
      wr16(16'h0460, 16'h0080);
      look_for(2'b11);
      // steady activity must darken the link indicator within two phases
      st <= 12'h003;
      dark_win <= 1'b1;
      idle(450);
      dark_win <= 1'b0;
      dark_chk <= 1'b1;
      st <= 12'h001;
      @(posedge clk);
      dark_chk <= 1'b0;
      st <= 12'h000;
      look_for(2'b00);
      st <= 12'h001;
      rd16(16'h0001, 16'h0000);
      wr16(16'h0460, 16'h00D0);
      look_for(2'b10);
      st <= 12'h000;
      look_for(2'b01);
      st <= 12'h001;
      look_for(2'b11);
      rd16(16'h0001, 16'h0000);
      look_for(2'b10);
      wr16(16'h0460, 16'h00E0);
      look_for(2'b10);
      st <= 12'h401;
      @(posedge clk);
      st <= 12'h001;
      idle(10);
      look_for(2'b11);
      st <= 12'h801;
      @(posedge clk);
      st <= 12'h001;
      look_for(2'b10);
      idle(3);
      close_out();
   end
endmodule
`default_nettype wire
